// >>> channel_source.sv
`timescale 1ns/10ps
module channel_source #(
    parameter int CHANNELS = 2
)(
    // Clock.
    input  wire logic                clock,
    // Level requested of the source.
    input  wire logic [CHANNELS-1:0] driveLevel,
    // Timer side of the pins.
    input  wire logic [CHANNELS-1:0] pinOut,
    input  wire logic [CHANNELS-1:0] pinOutEnable_n,
    // Resolved wire and spacing status.
    output logic [CHANNELS-1:0]      pinWire,
    output logic                     tooFast
);
    logic [CHANNELS-1:0] lastLevel;
    int                  sinceChange [CHANNELS];

    initial begin
        tooFast = 1'b0;
        lastLevel = '0;
        foreach (sinceChange[i]) sinceChange[i] = 4;
    end

    // The timer wins the wire while it drives; otherwise the source level shows.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            pinWire[i] = pinOutEnable_n[i] ? driveLevel[i] : pinOut[i];
        end
    end

    // Source edges closer than four counter clocks are flagged for the bench.
    always @(posedge clock) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (driveLevel[i] !== lastLevel[i]) begin
                if (sinceChange[i] < 4) tooFast <= 1'b1;
                sinceChange[i] <= 1;
            end else if (sinceChange[i] < 4) begin
                sinceChange[i] <= sinceChange[i] + 1;
            end
            lastLevel[i] <= driveLevel[i];
        end
    end
endmodule

// >>> count_bus_if.sv
`timescale 1ns/10ps
interface count_bus_if;
    logic [15:0] count;
    logic        tick;
    logic        countingUp;
    logic        wrapZero;
    logic        turnDown;
    logic        centerMode;
    logic        counterRun;
    logic        countWrite;
    logic [15:0] limit;
    modport source (output count, tick, countingUp, wrapZero, turnDown, centerMode, counterRun,
                    countWrite, limit);
    modport sink   (input count, tick, countingUp, wrapZero, turnDown, centerMode, counterRun,
                    countWrite, limit);
endinterface

// >>> test_timer_capture_pwm_channels.sv
`timescale 1ns/10ps
module test_timer_capture_pwm_channels
    import timer_pwm_pkg::*;
;
    typedef struct {
        logic        center;
        logic [15:0] limit;
        logic [1:0]  edgeSel;
        logic [15:0] value;
        int          period;
        int          high;
        int          flags;
    } row_s;
    // Flag count -1 means the match count is not checked for that row.
    row_s rows [8] = '{
        '{1'b0, 16'h0003, 2'h2, 16'h0002, 4, 2, 1}, '{1'b0, 16'h0003, 2'h2, 16'h0000, 4, 0, -1},
        '{1'b0, 16'h0003, 2'h2, 16'h0005, 4, 4, 0}, '{1'b0, 16'h0003, 2'h1, 16'h0001, 4, 3, 1},
        '{1'b1, 16'h0004, 2'h2, 16'h0002, 8, 4, 2}, '{1'b1, 16'h0004, 2'h2, 16'h0000, 8, 0, -1},
        '{1'b1, 16'h0004, 2'h2, 16'h0006, 8, 8, 1}, '{1'b1, 16'h0004, 2'h1, 16'h0001, 8, 6, 2}};
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  counterClockMode = 2'h0;
    logic [2:0]  prescaleSelect = 3'h0;
    logic        centerAlignSelect = 1'b0;
    logic [15:0] periodLimitData = 16'h0000;
    logic        periodLimitWrite = 1'b0;
    logic        countRegisterWrite = 1'b0;
    logic        overflowFlagClear = 1'b0;
    logic [3:0]  channelModeSelect = 4'h0;
    logic [3:0]  edgeLevelSelect = 4'h0;
    logic [1:0]  channelIrqEnable = 2'h0;
    logic [15:0] channelValueData = 16'h0000;
    logic [1:0]  channelValueWrite = 2'h0;
    logic [1:0]  channelFlagClear = 2'h0;
    logic [1:0]  driveLevel = 2'h0;
    logic [15:0] countRegister;
    logic [15:0] periodLimit;
    logic        overflowFlag;
    logic [1:0]  pinOut;
    logic [1:0]  pinOutEnable_n;
    logic [1:0]  pinWire;
    logic [31:0] channelValue;
    logic [1:0]  channelFlag;
    logic [1:0]  channelIrq;
    logic        tooFast;
    count_t      c0;
    int          failures = 0;
    int          comparisons = 0;
    int          high;
    int          ovf;
    int          flg;

    always #12.5 clock = ~clock;

    timer_pwm_module #(.CHANNELS(2)) u_dut (
        .clock(clock), .rst(rst), .counterClockMode(counterClockMode), .externalTick(1'b0),
        .prescaleSelect(prescaleSelect), .centerAlignSelect(centerAlignSelect),
        .periodLimitData(periodLimitData), .periodLimitWrite(periodLimitWrite),
        .countRegisterWrite(countRegisterWrite), .overflowFlagClear(overflowFlagClear),
        .countRegister(countRegister), .periodLimit(periodLimit), .overflowFlag(overflowFlag),
        .channelModeSelect(channelModeSelect), .edgeLevelSelect(edgeLevelSelect),
        .channelIrqEnable(channelIrqEnable), .channelValueData(channelValueData),
        .channelValueWrite(channelValueWrite), .channelFlagClear(channelFlagClear),
        .channelPinIn(pinWire), .channelPinOut(pinOut), .channelPinOutEnable_n(pinOutEnable_n),
        .channelValue(channelValue), .channelFlag(channelFlag), .channelIrq(channelIrq));

    channel_source #(.CHANNELS(2)) u_src (
        .clock(clock), .driveLevel(driveLevel), .pinOut(pinOut),
        .pinOutEnable_n(pinOutEnable_n), .pinWire(pinWire), .tooFast(tooFast));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic writeLimit(input logic [15:0] v);
        periodLimitData = v;
        periodLimitWrite = 1'b1;
        @(negedge clock);
        periodLimitWrite = 1'b0;
    endtask

    task automatic writeValue(input int ch, input logic [15:0] v);
        channelValueData = v;
        channelValueWrite[ch] = 1'b1;
        @(negedge clock);
        channelValueWrite = 2'h0;
    endtask

    task automatic pulseCount();
        countRegisterWrite = 1'b1;
        @(negedge clock);
        countRegisterWrite = 1'b0;
    endtask

    task automatic results();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #(25ns * 20000);
        failures++;
        results();
    end

    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        check("countStopped", 16'h0000, countRegister);
        check("limitReset", 16'hFFFF, periodLimit);
        check("resetFlags", 16'h0000, {13'h0, overflowFlag, channelFlag});
        check("pinsReleased", 16'h0003, {14'h0, pinOutEnable_n});
        foreach (rows[r]) begin
            counterClockMode = 2'h0;
            centerAlignSelect = rows[r].center;
            channelModeSelect = rows[r].center ? 4'hA : 4'h2;
            edgeLevelSelect = {2'h0, rows[r].edgeSel};
            channelIrqEnable = 2'h1;
            overflowFlagClear = 1'b1;
            channelFlagClear = 2'h3;
            @(negedge clock);
            writeLimit(rows[r].limit);
            check("limitStopped", rows[r].limit, periodLimit);
            writeValue(0, rows[r].value);
            pulseCount();
            counterClockMode = 2'h1;
            repeat (2 * rows[r].period + 2) @(negedge clock);
            high = 0;
            ovf = 0;
            flg = 0;
            repeat (2 * rows[r].period) begin
                @(negedge clock);
                high += pinWire[0];
                ovf += overflowFlag;
                flg += channelFlag[0];
                check("countInLimit", 16'h0001, 16'(countRegister <= rows[r].limit));
                check("irq", {14'h0, channelFlag & channelIrqEnable}, {14'h0, channelIrq});
                check("pinDriven", 16'h0000, {15'h0, pinOutEnable_n[0]});
            end
            check("highCycles", 16'(2 * rows[r].high), 16'(high));
            check("overflows", 16'h0002, 16'(ovf));
            if (rows[r].flags >= 0) check("matches", 16'(2 * rows[r].flags), 16'(flg));
        end
        counterClockMode = 2'h0;
        centerAlignSelect = 1'b0;
        channelModeSelect = 4'h0;
        edgeLevelSelect = 4'h0;
        @(negedge clock);
        writeLimit(16'h0000);
        pulseCount();
        counterClockMode = 2'h1;
        repeat (3) @(negedge clock);
        repeat (4) begin
            @(negedge clock);
            check("zeroLimitCount", 16'h0000, countRegister);
            check("zeroLimitFlag", 16'h0001, {15'h0, overflowFlag});
        end
        writeLimit(16'h0007);
        for (int k = 0; k < 20 && countRegister !== 16'h0001; k++) @(negedge clock);
        writeLimit(16'h0003);
        check("limitHeld", 16'h0007, periodLimit);
        for (int k = 0; k < 10 && periodLimit !== 16'h0003; k++) @(negedge clock);
        check("limitAtWrap", 16'h0003, periodLimit);
        check("wrapCount", 16'h0000, countRegister);
        for (int k = 0; k < 10 && countRegister !== 16'h0002; k++) @(negedge clock);
        pulseCount();
        check("countWrite", 16'h0000, countRegister);
        writeLimit(16'hFFFF);
        edgeLevelSelect = 4'h4;
        overflowFlagClear = 1'b0;
        repeat (6) @(negedge clock);
        channelFlagClear = 2'h0;
        c0 = countRegister;
        driveLevel[1] = 1'b1;
        repeat (2) @(negedge clock);
        check("flagEarly", 16'h0000, {15'h0, channelFlag[1]});
        @(negedge clock);
        check("flagThird", 16'h0001, {15'h0, channelFlag[1]});
        check("captured", c0 + 16'h0002, channelValue[31:16]);
        check("irqMasked", 16'h0000, {15'h0, channelIrq[1]});
        channelIrqEnable = 2'h3;
        writeValue(1, 16'h1234);
        check("irqRaised", 16'h0001, {15'h0, channelIrq[1]});
        check("valueKept", c0 + 16'h0002, channelValue[31:16]);
        counterClockMode = 2'h0;
        @(negedge clock);
        writeLimit(16'h0010);
        for (int e = 0; e < 4; e++) begin
            counterClockMode = 2'h0;
            channelModeSelect[1:0] = 2'h0;
            edgeLevelSelect[1:0] = 2'h0;
            channelFlagClear = 2'h1;
            @(negedge clock);
            channelFlagClear = 2'h0;
            pulseCount();
            channelModeSelect[1:0] = 2'h1;
            edgeLevelSelect[1:0] = e[1:0];
            writeValue(0, 16'h0005);
            check("compareValue", 16'h0005, channelValue[15:0]);
            check("entryLevel", 16'(e == 2), {15'h0, pinOut[0]});
            check("enableNoEdge", 16'(e == 0), {15'h0, pinOutEnable_n[0]});
            counterClockMode = 2'h1;
            for (int k = 0; k < 20 && channelFlag[0] !== 1'b1; k++) @(negedge clock);
            check("matchFlag", 16'h0001, {15'h0, channelFlag[0]});
            repeat (2) @(negedge clock);
            check("matchLevel", 16'(e[0]), {15'h0, pinOut[0]});
            pulseCount();
            check("keptOnCountWrite", 16'(e[0]), {15'h0, pinOut[0]});
        end
        prescaleSelect = 3'h1;
        pulseCount();
        repeat (4) @(negedge clock);
        check("prescaled", 16'h0002, countRegister);
        check("sourceSpacing", 16'h0000, {15'h0, tooFast});
        rst = 1'b1;
        @(negedge clock);
        check("midResetLimit", 16'hFFFF, periodLimit);
        check("midResetFlags", 16'h0000, {13'h0, overflowFlag, channelFlag});
        results();
    end
endmodule

// >>> timer_channel.sv
`timescale 1ns/10ps
`include "timer_pwm_defs.svh"
module timer_channel
    import timer_pwm_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Counter state.
    count_bus_if.sink        cb,
    // Configuration.
    input  wire logic [1:0]  modeSelect,
    input  wire logic [1:0]  edgeSelect,
    input  wire logic        irqEnable,
    input  wire logic [15:0] valueWriteData,
    input  wire logic        valueWrite,
    input  wire logic        flagClear,
    // Pin.
    input  wire logic        pinIn,
    output logic             pinOut,
    output logic             pinDrive,
    // Status.
    output logic [15:0]      channelValue,
    output logic             channelFlag,
    output logic             channelIrq
);
    logic [15:0] pendValue;
    logic        pendValid;
    logic [1:0]  pinSync;
    logic        pinLast;
    logic        captureLate;
    logic [15:0] edgeNext;
    logic [1:0]  lastMode;
    logic        isCapture;
    logic        isCompare;
    logic        isPwm;
    logic        match;
    logic        invert;
    logic        edgeSeen;
    logic        setFlag;

    assign isCapture = !cb.centerMode && modeSelect == `MODE_CAPTURE && edgeSelect != `EDGE_NONE;
    assign isCompare = !cb.centerMode && modeSelect == `MODE_COMPARE;
    assign isPwm     = modeSelect == `MODE_PWM;
    assign match     = cb.tick && cb.count == channelValue;
    assign invert    = edgeSelect[0];
    // A capture channel leaves its pin to the outside source.
    assign pinDrive  = modeSelect == `MODE_CAPTURE || edgeSelect == `EDGE_NONE;
    assign edgeNext  = cb.wrapZero ? `CNT_RESET : cb.count + 16'h0001;
    assign edgeSeen  = (edgeSelect[0] && pinSync[1] && !pinLast) ||
                       (edgeSelect[1] && !pinSync[1] && pinLast);

    // Two sync stages and an edge register: the edge is seen at the third clock edge.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinSync <= 2'h0;
            pinLast <= 1'b0;
        end else begin
            pinSync <= {pinSync[0], pinIn};
            pinLast <= pinSync[1];
        end
    end
    assign captureLate = isCapture && edgeSeen;

    // Channel value with write buffering.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            channelValue <= `VALUE_RESET;
            pendValue    <= `VALUE_RESET;
            pendValid    <= 1'b0;
        end else if (isCapture) begin
            pendValid <= 1'b0;
            if (captureLate) begin
                channelValue <= cb.count;
            end
        end else if (valueWrite && !cb.counterRun) begin
            channelValue <= valueWriteData;
            pendValid    <= 1'b0;
        end else begin
            if (valueWrite) begin
                pendValue <= valueWriteData;
                pendValid <= 1'b1;
            end
            if (pendValid && !valueWrite) begin
                if ((isCompare && cb.tick) ||
                    (isPwm && !cb.centerMode && cb.wrapZero) ||
                    (isPwm && cb.centerMode && cb.turnDown)) begin
                    channelValue <= pendValue;
                    pendValid    <= 1'b0;
                end
            end
        end
    end

    // Flag: a set in the same cycle as a clear wins.
    always_comb begin
        setFlag = 1'b0;
        if (isCapture) begin
            setFlag = captureLate;
        end else if (isCompare) begin
            setFlag = match;
        end else if (isPwm && !cb.centerMode) begin
            setFlag = match && channelValue <= cb.limit;
        end else if (isPwm && cb.centerMode) begin
            setFlag = match || (cb.turnDown && channelValue > cb.limit);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            channelFlag <= 1'b0;
        end else if (setFlag) begin
            channelFlag <= 1'b1;
        end else if (flagClear) begin
            channelFlag <= 1'b0;
        end
    end

    assign channelIrq = channelFlag && irqEnable;

    // Output level.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinOut  <= 1'b0;
            lastMode <= `MODE_CAPTURE;
        end else begin
            lastMode <= modeSelect;
            if (isCompare && lastMode != `MODE_COMPARE) begin
                pinOut <= (edgeSelect == `EDGE_FALL);
            end else if (isCompare) begin
                if (match) begin
                    unique case (edgeSelect)
                        `EDGE_RISE: pinOut <= !pinOut;
                        `EDGE_FALL: pinOut <= 1'b0;
                        `EDGE_BOTH: pinOut <= 1'b1;
                        `EDGE_NONE: pinOut <= pinOut;
                    endcase
                end
            end else if (cb.countWrite) begin
                pinOut <= 1'b0;
            end else if (isPwm && !cb.centerMode) begin
                // The level follows the count being loaded, so the width equals the value, up to the whole period.
                if (cb.tick) begin
                    pinOut <= (edgeNext < channelValue) ? !invert : invert;
                end
            end else if (isPwm && cb.centerMode) begin
                if (channelValue == `VALUE_RESET) begin
                    pinOut <= invert;
                end else if (channelValue > cb.limit) begin
                    pinOut <= !invert;
                end else if (match && !cb.countingUp) begin
                    pinOut <= !invert;
                end else if (match && cb.countingUp) begin
                    pinOut <= invert;
                end
            end
        end
    end

    a_flag_irq_tie: assert property (@(posedge clock) disable iff (rst)
        channelIrq == (channelFlag && irqEnable))
        else $error("channel interrupt does not follow flag and enable");
    a_capture_delay: assert property (@(posedge clock) disable iff (rst)
        (isCapture && edgeSeen) |=> channelFlag)
        else $error("capture flag not set on time");
    a_capture_lock: assert property (@(posedge clock) disable iff (rst)
        (isCapture && $past(isCapture) && !captureLate) |=> $stable(channelValue) || !isCapture)
        else $error("channel value changed in capture without event");
endmodule

// >>> timer_pwm_defs.svh
`ifndef TIMER_PWM_DEFS_SVH
`define TIMER_PWM_DEFS_SVH

`define CNT_WIDTH        16
`define CNT_RESET        16'h0000
`define LIMIT_RESET      16'hFFFF
`define VALUE_RESET      16'h0000
`define CLOCK_MODE_OFF   2'h0
`define MODE_CAPTURE     2'h0
`define MODE_COMPARE     2'h1
`define MODE_PWM         2'h2
`define EDGE_NONE        2'h0
`define EDGE_RISE        2'h1
`define EDGE_FALL        2'h2
`define EDGE_BOTH        2'h3
`define PRESCALE_WIDTH   7
`define CAPTURE_STAGES   2

`endif

// >>> timer_pwm_module.sv
`timescale 1ns/10ps
`include "timer_pwm_defs.svh"
module timer_pwm_module
    import timer_pwm_pkg::*;
#(
    parameter int CHANNELS = 2
)(
    // Clock and reset.
    input  wire logic                  clock,
    input  wire logic                  rst,
    // Counter control.
    input  wire logic [1:0]            counterClockMode,
    input  wire logic                  externalTick,
    input  wire logic [2:0]            prescaleSelect,
    input  wire logic                  centerAlignSelect,
    input  wire logic [15:0]           periodLimitData,
    input  wire logic                  periodLimitWrite,
    input  wire logic                  countRegisterWrite,
    input  wire logic                  overflowFlagClear,
    // Counter status.
    output logic [15:0]                countRegister,
    output logic [15:0]                periodLimit,
    output logic                       overflowFlag,
    // Channel configuration.
    input  wire logic [2*CHANNELS-1:0] channelModeSelect,
    input  wire logic [2*CHANNELS-1:0] edgeLevelSelect,
    input  wire logic [CHANNELS-1:0]   channelIrqEnable,
    input  wire logic [15:0]           channelValueData,
    input  wire logic [CHANNELS-1:0]   channelValueWrite,
    input  wire logic [CHANNELS-1:0]   channelFlagClear,
    // Channel pins.
    input  wire logic [CHANNELS-1:0]   channelPinIn,
    output logic [CHANNELS-1:0]        channelPinOut,
    output logic [CHANNELS-1:0]        channelPinOutEnable_n,
    // Channel status.
    output logic [16*CHANNELS-1:0]     channelValue,
    output logic [CHANNELS-1:0]        channelFlag,
    output logic [CHANNELS-1:0]        channelIrq
);
    count_bus_if cb();

    logic [`PRESCALE_WIDTH-1:0] prescaleCount;
    logic                       sourceTick;
    logic                       tick;
    logic                       running;
    count_dir_e                 direction;
    logic [15:0]                pendLimit;
    logic                       pendLimitValid;
    logic                       wrapZero;
    logic                       turnDown;
    logic [`PRESCALE_WIDTH-1:0] prescaleMax;

    // Clock mode 1 counts clock edges, mode 2 counts external ticks, both through the prescaler.
    assign running     = counterClockMode != `CLOCK_MODE_OFF;
    assign sourceTick  = counterClockMode == 2'h1 ? 1'b1 :
                         counterClockMode == 2'h2 ? externalTick : 1'b0;
    assign prescaleMax = `PRESCALE_WIDTH'((1 << prescaleSelect) - 1);
    assign tick        = running && sourceTick && prescaleCount == prescaleMax;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescaleCount <= '0;
        end else if (countRegisterWrite || !running) begin
            prescaleCount <= '0;
        end else if (sourceTick) begin
            prescaleCount <= tick ? '0 : prescaleCount + 1'b1;
        end
    end

    assign wrapZero = tick && !centerAlignSelect && countRegister >= periodLimit;
    assign turnDown = tick && centerAlignSelect && direction == DIR_UP &&
                      countRegister >= periodLimit;

    // Counter.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            countRegister <= `CNT_RESET;
            direction     <= DIR_UP;
        end else if (countRegisterWrite) begin
            countRegister <= `CNT_RESET;
            direction     <= DIR_UP;
        end else if (tick) begin
            if (!centerAlignSelect) begin
                direction <= DIR_UP;
                if (wrapZero) begin
                    countRegister <= `CNT_RESET;
                end else begin
                    countRegister <= countRegister + 16'h0001;
                end
            end else if (direction == DIR_UP) begin
                if (turnDown) begin
                    countRegister <= countRegister - 16'h0001;
                    direction     <= DIR_DOWN;
                end else begin
                    countRegister <= countRegister + 16'h0001;
                end
            end else begin
                if (countRegister == `CNT_RESET || countRegister == 16'h0001) begin
                    direction <= DIR_UP;
                end
                countRegister <= countRegister - 16'h0001;
            end
        end
    end

    // Period limit with write buffer.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            periodLimit    <= `LIMIT_RESET;
            pendLimit      <= `LIMIT_RESET;
            pendLimitValid <= 1'b0;
        end else if (periodLimitWrite && !running) begin
            periodLimit    <= periodLimitData;
            pendLimitValid <= 1'b0;
        end else if (periodLimitWrite) begin
            pendLimit      <= periodLimitData;
            pendLimitValid <= 1'b1;
        end else if (pendLimitValid && (wrapZero || turnDown)) begin
            periodLimit    <= pendLimit;
            pendLimitValid <= 1'b0;
        end
    end

    // Overflow flag; a set beats a simultaneous clear.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overflowFlag <= 1'b0;
        end else if (wrapZero || turnDown) begin
            overflowFlag <= 1'b1;
        end else if (overflowFlagClear) begin
            overflowFlag <= 1'b0;
        end
    end

    assign cb.count      = countRegister;
    assign cb.tick       = tick;
    assign cb.countingUp = direction == DIR_UP;
    assign cb.wrapZero   = wrapZero;
    assign cb.turnDown   = turnDown;
    assign cb.centerMode = centerAlignSelect;
    assign cb.counterRun = running;
    assign cb.countWrite = countRegisterWrite;
    assign cb.limit      = periodLimit;

    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        timer_channel u_ch (
            .clock          (clock),
            .rst            (rst),
            .cb             (cb),
            .modeSelect     (channelModeSelect[2*i +: 2]),
            .edgeSelect     (edgeLevelSelect[2*i +: 2]),
            .irqEnable      (channelIrqEnable[i]),
            .valueWriteData (channelValueData),
            .valueWrite     (channelValueWrite[i]),
            .flagClear      (channelFlagClear[i]),
            .pinIn          (channelPinIn[i]),
            .pinOut         (channelPinOut[i]),
            .pinDrive       (channelPinOutEnable_n[i]),
            .channelValue   (channelValue[16*i +: 16]),
            .channelFlag    (channelFlag[i]),
            .channelIrq     (channelIrq[i])
        );
    end

    a_up_wrap: assert property (@(posedge clock) disable iff (rst)
        (tick && !centerAlignSelect && countRegister == periodLimit && !countRegisterWrite)
        |=> countRegister == 16'h0000)
        else $error("counter did not reload zero at limit");
    a_wrap_flag: assert property (@(posedge clock) disable iff (rst)
        wrapZero |=> overflowFlag)
        else $error("overflow flag missing after wrap");
    a_zero_limit: assert property (@(posedge clock) disable iff (rst)
        (tick && !centerAlignSelect && periodLimit == 16'h0000 && countRegister == 16'h0000)
        |=> overflowFlag)
        else $error("zero limit overflow not flagged");
    a_center_turn: assert property (@(posedge clock) disable iff (rst)
        (turnDown && !countRegisterWrite) |=> overflowFlag && direction == DIR_DOWN)
        else $error("center turn not flagged");
    a_count_clear: assert property (@(posedge clock) disable iff (rst)
        countRegisterWrite |=> countRegister == 16'h0000)
        else $error("count write did not clear counter");
    a_stopped_hold: assert property (@(posedge clock) disable iff (rst)
        (!running && !countRegisterWrite) |=> $stable(countRegister))
        else $error("counter moved while stopped");
    a_limit_direct: assert property (@(posedge clock) disable iff (rst)
        (periodLimitWrite && !running) |=> periodLimit == $past(periodLimitData))
        else $error("stopped limit write not immediate");
    a_limit_hold: assert property (@(posedge clock) disable iff (rst)
        (running && !periodLimitWrite && !wrapZero && !turnDown) |=> $stable(periodLimit))
        else $error("limit changed outside boundary");
endmodule

// >>> timer_pwm_pkg.sv
package timer_pwm_pkg;
    typedef enum logic [1:0] {
        DIR_UP   = 2'b00,
        DIR_DOWN = 2'b01
    } count_dir_e;
    typedef logic [15:0] count_t;
endpackage
